// [logic/sbsram_pkg.sv]
// constants and types for the burst sram cycle decode block
package sbsram_pkg;
   localparam int unsigned LANES = 4;
   localparam int unsigned LANE_BITS = 8;
   localparam int unsigned ADDR_BITS = 19;
   localparam int unsigned BURST_BITS = 2;
   localparam logic [1:0] BURST_STEP = 2'h1;
   localparam logic [1:0] BURST_ZERO = 2'h0;

   // cycle types, one-hot
   typedef enum logic [5:0] {
      SB_IDLE = 6'h01,
      SB_DESEL = 6'h02,
      SB_SLEEP = 6'h04,
      SB_READ = 6'h08,
      SB_WRITE = 6'h10,
      SB_HOLD = 6'h20
   } sbsram_cycle_type;
endpackage

// [logic/sbsram_lane_if.sv]
// carrier between cycle decode and the lane write block
`timescale 1ns/100ps
`default_nettype none
interface sbsram_lane_if;
   logic global_write_n;
   logic lane_write_enable_n;
   logic [sbsram_pkg::LANES-1:0] lane_write_select_n;
   logic any_write;
   logic [sbsram_pkg::LANES-1:0] lane_mask;
   modport decode (output global_write_n, output lane_write_enable_n,
      output lane_write_select_n, input any_write, input lane_mask);
   modport lanes (input global_write_n, input lane_write_enable_n,
      input lane_write_select_n, output any_write, output lane_mask);
endinterface
`default_nettype wire

// [logic/sbsram_lanes.sv]
// write detect and byte lane mask
`timescale 1ns/100ps
`default_nettype none
module sbsram_lanes (
   sbsram_lane_if.lanes lif
);
   always_comb begin
      lif.any_write = !lif.global_write_n ||
         (!lif.lane_write_enable_n && !(&lif.lane_write_select_n));
      if (!lif.global_write_n) begin
         lif.lane_mask = '1;
      end else if (!lif.lane_write_enable_n) begin
         lif.lane_mask = ~lif.lane_write_select_n;
      end else begin
         lif.lane_mask = '0;
      end
   end
endmodule
`default_nettype wire

// [logic/sbsram_decode.sv]
// cycle decode, burst counter and data drive of the burst sram
`timescale 1ns/100ps
`default_nettype none
module sbsram_decode #(
   parameter int unsigned LANES = sbsram_pkg::LANES,
   parameter int unsigned LANE_BITS = sbsram_pkg::LANE_BITS,
   parameter int unsigned ADDR_BITS = sbsram_pkg::ADDR_BITS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // selects and strobes
   input wire logic chip_sel_first_n,
   input wire logic chip_sel_second,
   input wire logic chip_sel_third_n,
   input wire logic sleep_request,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic burst_mode,
   input wire logic output_enable_n,
   // write inputs
   input wire logic global_write_n,
   input wire logic lane_write_enable_n,
   input wire logic [LANES-1:0] lane_write_select_n,
   // address and data in
   input wire logic [ADDR_BITS-1:0] addr,
   input wire logic [LANES*LANE_BITS-1:0] data_in,
   input wire logic [LANES-1:0] parity_io_in,
   // core access
   output logic [ADDR_BITS-1:0] core_addr,
   output logic core_read,
   output logic core_write,
   output logic [LANES-1:0] core_lane_mask,
   output logic [LANES*LANE_BITS-1:0] core_wdata,
   output logic [LANES-1:0] core_wparity,
   // data bus drive, enable low while driving, and cycle type
   output logic data_oe_n,
   output logic parity_io_oe_n,
   output logic [5:0] cycle_state
);
   localparam int unsigned BB = sbsram_pkg::BURST_BITS;

   typedef struct packed {
      sbsram_pkg::sbsram_cycle_type cyc;
      logic [ADDR_BITS-1:0] base;
      logic [BB-1:0] start;
      logic [BB-1:0] step;
      logic wr_armed;
      logic [ADDR_BITS-1:0] core_addr;
      logic core_read;
      logic core_write;
      logic [LANES-1:0] mask;
      logic [LANES*LANE_BITS-1:0] wdata;
      logic [LANES-1:0] wpar;
   } sbsram_state_type;

   sbsram_state_type state_reg;
   sbsram_state_type state_next;

   // -----------------------------------------
   // lane decode
   // -----------------------------------------
   sbsram_lane_if lif ();
   assign lif.global_write_n = global_write_n;
   assign lif.lane_write_enable_n = lane_write_enable_n;
   assign lif.lane_write_select_n = lane_write_select_n;

   sbsram_lanes u_lanes (
      .lif(lif)
   );

   all_high_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (global_write_n && lane_write_enable_n && (&lane_write_select_n)) |-> !lif.any_write)
      else $error("write seen with all write inputs high");

   function automatic logic [BB-1:0] burst_low(input logic [BB-1:0] start,
      input logic [BB-1:0] step, input logic inter);
      if (inter) begin
         burst_low = start ^ step;
      end else begin
         burst_low = start + step;
      end
   endfunction

   logic selected;
   logic proc_start;
   logic ctrl_start;
   logic any_start;
   assign selected = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
   assign proc_start = !proc_addr_strobe_n && !chip_sel_first_n;
   // ignored processor strobe lets controller start
   assign ctrl_start = !ctrl_addr_strobe_n && !proc_start;
   assign any_start = proc_start || ctrl_start;

   // -----------------------------------------
   // cycle decode
   // -----------------------------------------
   always_comb begin
      logic [BB-1:0] nstep;
      nstep = '0;
      state_next = state_reg;
      state_next.core_read = 1'b0;
      state_next.core_write = 1'b0;
      state_next.mask = '0;
      if (sleep_request) begin
         state_next.cyc = sbsram_pkg::SB_SLEEP;
         state_next.wr_armed = 1'b0;
      end else if (any_start && !selected) begin
         state_next.cyc = sbsram_pkg::SB_DESEL;
         state_next.wr_armed = 1'b0;
      end else if (proc_start || (ctrl_start && !lif.any_write)) begin
         state_next.cyc = sbsram_pkg::SB_READ;
         state_next.base = addr;
         state_next.start = addr[BB-1:0];
         state_next.step = sbsram_pkg::BURST_ZERO;
         state_next.core_addr = addr;
         state_next.core_read = 1'b1;
         state_next.wr_armed = 1'b1;
      end else if (ctrl_start) begin
         state_next.cyc = sbsram_pkg::SB_WRITE;
         state_next.base = addr;
         state_next.start = addr[BB-1:0];
         state_next.step = sbsram_pkg::BURST_ZERO;
         state_next.core_addr = addr;
         state_next.core_write = 1'b1;
         state_next.mask = lif.lane_mask;
         state_next.wdata = data_in;
         state_next.wpar = parity_io_in;
         state_next.wr_armed = 1'b1;
      end else if (state_reg.wr_armed) begin
         nstep = burst_advance_n ? state_reg.step
            : state_reg.step + sbsram_pkg::BURST_STEP;
         state_next.step = nstep;
         state_next.core_addr = {state_reg.base[ADDR_BITS-1:BB],
            burst_low(state_reg.start, nstep, burst_mode)};
         if (lif.any_write) begin
            state_next.cyc = burst_advance_n ? sbsram_pkg::SB_HOLD
               : sbsram_pkg::SB_WRITE;
            state_next.core_write = 1'b1;
            state_next.mask = lif.lane_mask;
            state_next.wdata = data_in;
            state_next.wpar = parity_io_in;
         end else begin
            state_next.cyc = sbsram_pkg::SB_READ;
            state_next.core_read = 1'b1;
         end
      end else begin
         state_next.cyc = sbsram_pkg::SB_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= '{cyc: sbsram_pkg::SB_IDLE, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   // -----------------------------------------
   // outputs
   // -----------------------------------------
   assign core_addr = state_reg.core_addr;
   assign core_read = state_reg.core_read;
   assign core_write = state_reg.core_write;
   assign core_lane_mask = state_reg.mask;
   assign core_wdata = state_reg.wdata;
   assign core_wparity = state_reg.wpar;
   assign cycle_state = state_reg.cyc;

   logic drive_n;
   assign drive_n = !(state_reg.core_read && !output_enable_n);
   assign data_oe_n = drive_n;
   assign parity_io_oe_n = drive_n;

   // -----------------------------------------
   // checks
   // -----------------------------------------
   write_floats_bus_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      core_write |-> data_oe_n)
      else $error("bus driven during write");
   proc_start_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!sleep_request && selected && !proc_addr_strobe_n) |=> core_read && !core_write)
      else $error("processor start not a read");
   ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!sleep_request && selected && proc_addr_strobe_n && !ctrl_addr_strobe_n
      && lif.any_write) |=> core_write && core_addr == $past(addr))
      else $error("controller write start missed");
   sleep_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      sleep_request |=> !core_read && !core_write && data_oe_n)
      else $error("access during sleep");
   desel_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!sleep_request && any_start && !selected) |=> !core_read && !core_write)
      else $error("access on deselect");
   hold_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!sleep_request && !any_start && state_reg.wr_armed && burst_advance_n)
      |=> core_addr == $past(state_reg.core_addr))
      else $error("suspend moved address");
   read_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (core_read && !output_enable_n) |-> !data_oe_n)
      else $error("read not driven");
   lane_mask_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!sleep_request && !any_start && state_reg.wr_armed && global_write_n
      && !lane_write_enable_n) |=> core_lane_mask == ~$past(lane_write_select_n))
      else $error("wrong lane mask");
endmodule
`default_nettype wire

// [tb/sbsram_master.sv]
// bus master model driving the burst sram pins
`timescale 1ns/100ps
`default_nettype none
module sbsram_master (
   // clock
   input wire logic ref_clk,
   // selects and strobes
   output logic chip_sel_first_n,
   output logic chip_sel_second,
   output logic chip_sel_third_n,
   output logic sleep_request,
   output logic proc_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic burst_advance_n,
   output logic burst_mode,
   output logic output_enable_n,
   // write inputs, address and data
   output logic global_write_n,
   output logic lane_write_enable_n,
   output logic [3:0] lane_write_select_n,
   output logic [18:0] addr,
   output logic [31:0] data_in,
   output logic [3:0] parity_io_in
);
   logic prev_wr = 1'b0;
   initial begin
      {chip_sel_first_n, chip_sel_second, chip_sel_third_n, sleep_request, proc_addr_strobe_n,
         ctrl_addr_strobe_n, burst_advance_n, burst_mode, output_enable_n, global_write_n,
         lane_write_enable_n} = 11'h477;
      {lane_write_select_n, addr, parity_io_in, data_in} = {4'hf, 55'h0};
   end
   task automatic drive(input logic [10:0] c, input logic [3:0] s, input logic [18:0] a,
      input logic [35:0] d);
      logic [10:0] c2;
      logic wrs;
      c2 = c;
      wrs = !c[1] | (!c[0] & !(&s));
      c2[2] = c[2] | (wrs & !prev_wr);
      prev_wr = wrs;
      @(posedge ref_clk);
      {chip_sel_first_n, chip_sel_second, chip_sel_third_n, sleep_request, proc_addr_strobe_n,
         ctrl_addr_strobe_n, burst_advance_n, burst_mode, output_enable_n, global_write_n,
         lane_write_enable_n} <= c2;
      lane_write_select_n <= s;
      addr <= a;
      // fresh pattern every cycle, so stale data never matches
      {parity_io_in, data_in} <= d;
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking testbench of the burst sram cycle decode
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [18:0] a;
      logic [3:0] m;
      logic [35:0] d;
      logic [5:0] st;
   } sbsram_exp_type;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic chip_sel_first_n, chip_sel_second, chip_sel_third_n, sleep_request;
   logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, burst_mode;
   logic output_enable_n, global_write_n, lane_write_enable_n;
   logic core_read, core_write, data_oe_n, parity_io_oe_n, open_b, md;
   logic [3:0] lane_write_select_n, parity_io_in, core_lane_mask, core_wparity;
   logic [18:0] addr, core_addr, base;
   logic [31:0] data_in, core_wdata;
   logic [5:0] cycle_state;
   logic [1:0] stp;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   sbsram_exp_type exp_q[$];
   sbsram_exp_type want, got;

   sbsram_master m (.*);
   sbsram_decode uut (.*);

   always #12.5 ref_clk = !ref_clk;

   task automatic chk(input string n, input logic [66:0] w, input logic [66:0] g);
      checks_done++;
      if (g !== w) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, w, g);
      end
   endtask

   task automatic final_report();
      chk("pending", 67'(0), 67'(exp_q.size()));
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // cs = {first_n, second, third_n}, k = {sleep, proc_n, ctrl_n, adv_n}, w = {gw, bwe, lanes}
   task automatic cyc(input logic [2:0] cs, input logic [3:0] k, input logic [5:0] w,
      input logic [18:0] a);
      logic [35:0] d;
      logic wrs, pe;
      sbsram_exp_type e;
      d = 36'({$urandom, $urandom});
      wrs = !w[5] | (!w[4] & !(&w[3:0]));
      pe = k[2] | cs[2];
      e = '0;
      e.st = 6'h10;
      if (!k[3]) begin
         if (!pe || !k[1]) begin
            open_b = !cs[2] & cs[1] & !cs[0];
            base = a;
            stp = 2'h0;
            e.rd = open_b & (!pe | !wrs);
            e.wr = open_b & pe & wrs;
         end else if (open_b) begin
            if (!k[0])
               stp = stp + 2'h1;
            e.rd = !wrs;
            e.wr = wrs;
            e.st = k[0] ? 6'h20 : 6'h10;
         end
      end else begin
         open_b = 1'b0;
      end
      e.a = {base[18:2], md ? base[1:0] ^ stp : base[1:0] + stp};
      if (e.wr) begin
         e.m = w[5] ? ~w[3:0] : 4'hf;
         e.d = d;
      end
      if (e.rd) begin
         e.st = 6'h08;
      end
      if (e.rd | e.wr) begin
         exp_q.push_back(e);
      end
      m.drive({cs, k, md, 1'($urandom), w[5:4]}, w[3:0], a, d);
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         final_report();
      end
   end

   always @(negedge ref_clk) begin
      if (resetn) begin
         want = '0;
         if (core_read === 1'b1 || core_write === 1'b1) begin
            if (exp_q.size() > 0) begin
               want = exp_q.pop_front();
            end
            got = {core_read, core_write, core_addr, core_lane_mask, core_wparity, core_wdata,
               cycle_state};
            if (!got.wr) begin
               got.m = '0;
               got.d = '0;
            end
            chk("access", want, got);
         end
         chk("drive", 67'({2{!(want.rd & !output_enable_n)}}), 67'({data_oe_n, parity_io_oe_n}));
      end
   end

   initial begin
      void'($urandom(25499));
      {md, open_b, base, stp} = '0;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         md = i[0];
         cyc(3'b010, 4'b0011, 6'h00, 19'($urandom));
         repeat (5) cyc(3'b110, 4'b0010, {2'b10, 4'($urandom)}, 19'($urandom));
         cyc(3'b111, 4'b0111, 6'h20, '0);
         cyc(3'b111, 4'b0111, 6'h3f, '0);
         cyc(3'b010, 4'b0101, {2'b10, 4'($urandom)}, 19'($urandom));
         cyc(3'b010, 4'b0110, 6'h3f, '0);
         cyc(3'b010, 4'b0101, 6'h3f, 19'($urandom));
         cyc(3'b000, 4'b0011, 6'h00, 19'($urandom));
         cyc(3'b011, 4'b0011, 6'h00, 19'($urandom));
         cyc(3'b110, 4'b0101, 6'h00, 19'($urandom));
         cyc(3'b111, 4'b0110, 6'h3f, '0);
         cyc(3'b010, 4'b1011, 6'h00, 19'($urandom));
         repeat (2) cyc(3'b110, 4'b0111, 6'h3f, '0);
      end
      repeat (3) @(posedge ref_clk);
      final_report();
   end
endmodule
`default_nettype wire
